// File: rtl/uart_line_status_flags.sv
// line status flags, receive error fifo and holding-empty tracking
module uart_line_status_flags #(
   parameter int RX_DEPTH = 16,
   parameter int TX_DEPTH = 16
) (
   input  wire logic        sys_clk,              // 100 MHz system clock
   input  wire logic        nrst,                 // sync reset, active low
   input  wire logic        hsel,                 // slave select
   input  wire logic [31:0] haddr,                // byte address
   input  wire logic [1:0]  htrans,               // transfer type
   input  wire logic        hwrite,               // 1 = write
   input  wire logic [2:0]  hsize,                // word only
   input  wire logic [31:0] hwdata,               // write data
   input  wire logic        hready,               // bus ready
   output logic             hreadyout,            // slave ready
   output logic      [31:0] hrdata,               // read data
   output logic             hresp,                // always okay
   input  wire logic        serial_receive_input, // rx pin, async
   input  wire logic        rx_bit_tick,          // one pulse per bit time
   input  wire logic        rx_char_valid,        // receiver char strobe
   input  wire logic [7:0]  rx_char_data,         // received char
   input  wire logic        rx_parity_err,        // char parity bad
   input  wire logic        rx_frame_err,         // char stop bit bad
   input  wire logic        tx_shift_load,        // char taken into shift reg
   input  wire logic        tx_shift_busy,        // shift reg holds a char
   output logic             tx_wr_valid,          // host char to transmitter
   output logic      [7:0]  tx_wr_data,           // that char
   output logic      [7:0]  line_status,          // live status copy
   output logic             irq                   // level interrupt
);

   localparam int AW = $clog2(RX_DEPTH);
   localparam int TW = $clog2(TX_DEPTH);

   // ==========================================================
   // bus slave
   uart_lsr_pkg::bus_state_t bus_state_reg;
   logic [7:0] addr_reg;
   logic       wr_reg;
   logic       act;
   logic [7:0] ctrl_reg;
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_en_reg;
   logic [7:0] lsr_next;
   logic       fifo_en;
   assign act = (bus_state_reg == uart_lsr_pkg::BUS_ACT);
   assign fifo_en = ctrl_reg[uart_lsr_pkg::CTRL_FIFO_EN];
   // take the address phase, answer after one wait cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bus_state_reg <= uart_lsr_pkg::BUS_IDLE;
         addr_reg      <= 8'h00;
         wr_reg        <= 1'b0;
         hreadyout     <= 1'b1;
      end else begin
         unique case (bus_state_reg)
            uart_lsr_pkg::BUS_IDLE: begin
               if (hsel && hready && htrans[1]) begin
                  bus_state_reg <= uart_lsr_pkg::BUS_ACT;
                  addr_reg      <= {haddr[7:2], 2'b00};
                  wr_reg        <= hwrite;
                  hreadyout     <= 1'b0;
               end
            end
            uart_lsr_pkg::BUS_ACT: begin
               bus_state_reg <= uart_lsr_pkg::BUS_IDLE;
               hreadyout     <= 1'b1;
            end
         endcase
      end
   end

   logic rd_data, rd_lsr, wr_data, wr_ctrl, wr_clr, wr_en;
   assign rd_data = act && !wr_reg && addr_reg == uart_lsr_pkg::OFS_DATA;
   assign rd_lsr  = act && !wr_reg && addr_reg == uart_lsr_pkg::OFS_LSR;
   assign wr_data = act && wr_reg && addr_reg == uart_lsr_pkg::OFS_DATA;
   assign wr_ctrl = act && wr_reg && addr_reg == uart_lsr_pkg::OFS_CTRL;
   assign wr_clr  = act && wr_reg && addr_reg == uart_lsr_pkg::OFS_IRQ_CLR;
   assign wr_en   = act && wr_reg && addr_reg == uart_lsr_pkg::OFS_IRQ_EN;
   // response is never an error; reads of holes return zero
   logic [10:0] head;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hrdata <= 32'h0000_0000;
         hresp  <= 1'b0;
      end else begin
         if (act && !wr_reg) begin
            unique case (addr_reg)
               uart_lsr_pkg::OFS_DATA:     hrdata <= {24'h000000, head[7:0]};
               uart_lsr_pkg::OFS_LSR:      hrdata <= {24'h000000, lsr_next};
               uart_lsr_pkg::OFS_CTRL:     hrdata <= {24'h000000, ctrl_reg};
               uart_lsr_pkg::OFS_IRQ_STAT: hrdata <= {29'h0000_0000, irq_stat_reg};
               uart_lsr_pkg::OFS_IRQ_EN:   hrdata <= {29'h0000_0000, irq_en_reg};
               default:                    hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control register; an lsr write falls to no register at all
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_reg <= uart_lsr_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= hwdata[7:0];
      end
   end

   // a mode change flushes both queues so counts stay coherent
   logic flush;
   assign flush = wr_ctrl && (hwdata[uart_lsr_pkg::CTRL_FIFO_EN] != fifo_en);

   // ==========================================================
   // break detector on the synchronised pin
   logic       rxd_meta_reg, rxd_sync_reg;
   logic [3:0] low_cnt_reg;
   logic       brk_armed_reg;
   logic       brk_hit;
   logic [3:0] frame_len;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
      end else begin
         rxd_meta_reg <= serial_receive_input;
         rxd_sync_reg <= rxd_meta_reg;
      end
   end

   assign frame_len = ctrl_reg[uart_lsr_pkg::CTRL_FLEN_LO +: 4];
   assign brk_hit   = brk_armed_reg && rx_bit_tick && !rxd_sync_reg
                      && (4'(low_cnt_reg + 4'h1) == frame_len);
   // count low bit times; disarm after one break until the line idles
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         low_cnt_reg   <= 4'h0;
         brk_armed_reg <= 1'b1;
      end else if (rxd_sync_reg) begin
         low_cnt_reg   <= 4'h0;
         brk_armed_reg <= 1'b1;
      end else if (brk_hit) begin
         low_cnt_reg   <= 4'h0;
         brk_armed_reg <= 1'b0;
      end else if (rx_bit_tick && brk_armed_reg) begin
         low_cnt_reg <= 4'(low_cnt_reg + 4'h1);
      end
   end

   // ==========================================================
   // receive fifo; non-fifo mode is the same queue one deep
   logic [AW-1:0] rx_wp_reg, rx_rp_reg;
   logic [AW:0]   rx_cnt_reg, rx_cap, err_cnt_reg;
   logic          rx_full, push_req, push_ok, overrun_set, pop;
   logic [10:0]   push_entry;
   logic          push_err, head_err, avail_d_reg, overrun_reg;

   assign rx_cap   = fifo_en ? (AW+1)'(RX_DEPTH) : (AW+1)'(1);
   assign rx_full  = rx_cnt_reg >= rx_cap;
   assign push_req = brk_hit || rx_char_valid;
   // a break char is all zero with framing and break set; it wins a tie
   assign push_entry = brk_hit ? {1'b1, 1'b1, 1'b0, 8'h00}
                               : {1'b0, rx_frame_err, rx_parity_err, rx_char_data};
   assign push_ok     = push_req && !rx_full;
   assign overrun_set = push_req && rx_full;
   assign pop         = rd_data && rx_cnt_reg != '0;
   assign push_err    = |push_entry[10:8];
   assign head_err    = |head[10:8];
   rx_entry_mem #(
      .WIDTH (uart_lsr_pkg::ENT_W),
      .DEPTH (RX_DEPTH),
      .AW    (AW)
   ) u_rx_mem (
      .sys_clk (sys_clk),
      .wen     (push_ok),
      .waddr   (rx_wp_reg),
      .wdata   (push_entry),
      .raddr   (rx_rp_reg),
      .rdata   (head)
   );

   // pointers and occupancy
   always_ff @(posedge sys_clk) begin
      if (!nrst || flush) begin
         rx_wp_reg  <= '0;
         rx_rp_reg  <= '0;
         rx_cnt_reg <= '0;
      end else begin
         if (push_ok) begin
            rx_wp_reg <= AW'(rx_wp_reg + 1'b1);
         end
         if (pop) begin
            rx_rp_reg <= AW'(rx_rp_reg + 1'b1);
         end
         rx_cnt_reg <= (AW+1)'(rx_cnt_reg + push_ok - pop);
      end
   end

   // count of stored chars that carry any error flag
   always_ff @(posedge sys_clk) begin
      if (!nrst || flush) begin
         err_cnt_reg <= '0;
      end else begin
         err_cnt_reg <= (AW+1)'(err_cnt_reg + (push_ok && push_err)
                                - (pop && head_err));
      end
   end

   // head word lags the pointer by one cycle, so data ready lags too
   always_ff @(posedge sys_clk) begin
      if (!nrst || flush) begin
         avail_d_reg <= 1'b0;
      end else begin
         avail_d_reg <= rx_cnt_reg != '0;
      end
   end

   // overrun is sticky until an lsr read; a new overrun beats the read
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         overrun_reg <= 1'b0;
      end else begin
         overrun_reg <= overrun_set || (overrun_reg && !rd_lsr);
      end
   end

   // ==========================================================
   // transmit holding occupancy; data itself goes to the transmitter
   logic [TW:0] tx_cnt_reg, tx_cnt_next, tx_cap;
   logic        tx_write, tx_take, thre_reg, temt_reg;

   assign tx_cap   = fifo_en ? (TW+1)'(TX_DEPTH) : (TW+1)'(1);
   assign tx_write = wr_data && tx_cnt_reg < tx_cap; // a write when full is lost
   assign tx_take  = tx_shift_load && tx_cnt_reg != '0;
   assign tx_cnt_next = (TW+1)'(tx_cnt_reg + tx_write - tx_take);
   always_ff @(posedge sys_clk) begin
      if (!nrst || flush) begin
         tx_cnt_reg <= '0;
      end else begin
         tx_cnt_reg <= tx_cnt_next;
      end
   end

   // flags follow the next count so a write clears at its own edge
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         thre_reg <= 1'b1;
         temt_reg <= 1'b1;
      end else if (flush) begin
         thre_reg <= 1'b1;
         temt_reg <= !tx_shift_busy;
      end else begin
         thre_reg <= tx_cnt_next == '0;
         temt_reg <= tx_cnt_next == '0 && !tx_shift_busy
                     && !tx_shift_load;
      end
   end

   // hand the written char on to the transmit datapath
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_wr_valid <= 1'b0;
         tx_wr_data  <= 8'h00;
      end else begin
         tx_wr_valid <= tx_write;
         if (tx_write) begin
            tx_wr_data <= hwdata[7:0];
         end
      end
   end

   // ==========================================================
   // line status assembly
   always_comb begin
      lsr_next = 8'h00;
      lsr_next[uart_lsr_pkg::LSR_DR]   = avail_d_reg;
      lsr_next[uart_lsr_pkg::LSR_OE]   = overrun_reg;
      lsr_next[uart_lsr_pkg::LSR_PE]   = avail_d_reg && head[uart_lsr_pkg::ENT_PAR];
      lsr_next[uart_lsr_pkg::LSR_FE]   = avail_d_reg && head[uart_lsr_pkg::ENT_FRM];
      lsr_next[uart_lsr_pkg::LSR_BI]   = avail_d_reg && head[uart_lsr_pkg::ENT_BRK];
      lsr_next[uart_lsr_pkg::LSR_THRE] = thre_reg;
      lsr_next[uart_lsr_pkg::LSR_TEMT] = temt_reg;
      lsr_next[uart_lsr_pkg::LSR_FERR] = fifo_en && err_cnt_reg != '0;
   end

   // live copy for the pins; only THRE and TEMT set out of reset (8'h60)
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         line_status <= 8'h60;
      end else begin
         line_status <= lsr_next;
      end
   end

   // ==========================================================
   // interrupts: sticky status, set wins over a clear
   logic [2:0] irq_set, irq_stat_next, irq_en_next;
   assign irq_set[uart_lsr_pkg::IRQ_RX]   = push_ok;
   assign irq_set[uart_lsr_pkg::IRQ_ERR]  = (push_ok && push_err) || overrun_set;
   assign irq_set[uart_lsr_pkg::IRQ_THRE] = thre_reg;
   assign irq_stat_next = irq_set | (irq_stat_reg & ~(wr_clr ? hwdata[2:0] : 3'h0));
   assign irq_en_next   = wr_en ? hwdata[2:0] : irq_en_reg;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         irq_stat_reg <= uart_lsr_pkg::IRQ_RESET;
         irq_en_reg   <= uart_lsr_pkg::IRQ_RESET;
         irq          <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_en_reg   <= irq_en_next;
         irq          <= |(irq_stat_next & irq_en_next);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_ferr_set: assert property (fifo_en && err_cnt_reg != '0 |=> line_status[7])
      else $error("error summary missing");
   a_ferr_clear: assert property (err_cnt_reg == '0 |=> !line_status[7])
      else $error("error summary stuck");
   a_temt_busy: assert property (tx_cnt_reg != '0 |=> !line_status[6])
      else $error("temt set with char held");
   a_temt_idle: assert property (tx_cnt_reg == '0 && !tx_shift_busy && !tx_shift_load && !tx_write && !flush
                                 |=> temt_reg)
      else $error("temt not set when idle");
   a_thre_write: assert property (tx_write && !tx_take |=> !thre_reg && !temt_reg)
      else $error("thre not cleared on write");
   a_thre_load: assert property (tx_cnt_reg == 1 && tx_shift_load && !tx_write && !flush
                                 |=> thre_reg ##1 line_status[5])
      else $error("thre not set after load");
   a_irq_thre: assert property (thre_reg && irq_en_reg[2] && !wr_en |=> irq)
      else $error("thre interrupt missing");
   a_brk_once: assert property (brk_hit ##1 !rxd_sync_reg |-> !brk_hit)
      else $error("second break char");
   a_overrun_keep: assert property (push_req && rx_full && !pop && !flush
                                    |=> rx_cnt_reg == $past(rx_cnt_reg) && overrun_reg)
      else $error("overrun stored a char");
   a_dr_clear: assert property ((rx_cnt_reg == '0) [*2] |=> !line_status[0])
      else $error("data ready with empty fifo");

   c_break: cover property (brk_hit && !rx_full);
   c_overrun: cover property (overrun_set);
   c_irq: cover property (!irq ##1 irq);
   c_tx_write: cover property (tx_write ##[1:20] tx_shift_load);

endmodule // uart_line_status_flags

// File: rtl/uart_lsr_pkg.sv
// constants, register map and field layout of the line status block
package uart_lsr_pkg;

   // ==========================================================
   // register byte offsets on the bus
   localparam logic [7:0] OFS_DATA     = 8'h00; // rx pop on read, tx write
   localparam logic [7:0] OFS_LSR      = 8'h04; // line_status, read-only
   localparam logic [7:0] OFS_CTRL     = 8'h08; // mode and break length
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c; // sticky events, read-only
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h10; // write one to clear
   localparam logic [7:0] OFS_IRQ_EN   = 8'h14; // event enables

   // ==========================================================
   // line_status bit positions
   localparam int LSR_DR   = 0; // receive data ready
   localparam int LSR_OE   = 1; // overrun
   localparam int LSR_PE   = 2; // parity error, head char
   localparam int LSR_FE   = 3; // framing error, head char
   localparam int LSR_BI   = 4; // break, head char
   localparam int LSR_THRE = 5; // holding empty
   localparam int LSR_TEMT = 6; // holding and shift empty
   localparam int LSR_FERR = 7; // any error in fifo

   // ==========================================================
   // control register layout and reset value
   localparam int         CTRL_FIFO_EN = 0;        // 1 = fifo mode
   localparam int         CTRL_FLEN_LO = 4;        // frame length in bit times
   localparam logic [7:0] CTRL_RESET   = 8'ha0;    // non-fifo, 10-bit frame

   // ==========================================================
   // interrupt bits
   localparam int         IRQ_RX   = 0;            // char entered rx fifo
   localparam int         IRQ_ERR  = 1;            // error char or overrun
   localparam int         IRQ_THRE = 2;            // holding empty
   localparam int         IRQ_W    = 3;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // ==========================================================
   // receive fifo entry layout: data then flags
   localparam int ENT_PAR = 8;
   localparam int ENT_FRM = 9;
   localparam int ENT_BRK = 10;
   localparam int ENT_W   = 11;

   // bus slave phase
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACT  = 2'b10
   } bus_state_t;

endpackage

// File: rtl/rx_entry_mem.sv
// small receive fifo storage with registered read data
module rx_entry_mem #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             sys_clk, // system clock
   input  wire logic             wen,     // write strobe
   input  wire logic [AW-1:0]    waddr,   // write address
   input  wire logic [WIDTH-1:0] wdata,   // write data
   input  wire logic [AW-1:0]    raddr,   // read address
   output logic      [WIDTH-1:0] rdata    // registered read data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // storage needs no reset, the pointers guard stale words
   always_ff @(posedge sys_clk) begin
      if (wen) begin
         mem[waddr] <= wdata;
      end
   end

   // read one cycle behind the address
   always_ff @(posedge sys_clk) begin
      rdata <= mem[raddr];
   end

endmodule // rx_entry_mem

// File: verification/tx_model.sv
// behavioural transmitter that takes chars from the holding side
module tx_model #(
   parameter int SHIFT_CYC = 60
) (
   input  wire logic sys_clk,       // system clock
   input  wire logic nrst,          // sync reset, active low
   input  wire logic go,            // 0 stalls the transmitter
   input  wire logic tx_wr_valid,   // host char handed over
   output logic      tx_shift_load, // head char taken
   output logic      tx_shift_busy, // shift reg holds a char
   output int        n_taken        // chars taken so far
);
   timeunit 1ns;
   timeprecision 1ps;
   int pend;
   int cnt;
   // ==========================================================
   // shift engine; busy from the cycle after load, so temt lags thre by a frame
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_shift_load <= 1'b0;
         tx_shift_busy <= 1'b0;
         pend          <= 0;
         cnt           <= 0;
         n_taken       <= 0;
      end else begin
         tx_shift_load <= 1'b0;
         if (tx_shift_load) begin
            tx_shift_busy <= 1'b1;
            cnt           <= SHIFT_CYC;
         end else if (cnt != 0) cnt <= cnt - 1;
         else tx_shift_busy <= 1'b0;
         // take only when idle and something is pending
         if (go && pend != 0 && !tx_shift_busy && !tx_shift_load) begin
            tx_shift_load <= 1'b1;
            n_taken       <= n_taken + 1;
            pend          <= pend - 1 + int'(tx_wr_valid);
         end else pend <= pend + int'(tx_wr_valid);
      end
   end
endmodule // tx_model

// File: verification/tb_top.sv
// register level bench for the line status block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_DAT = uart_lsr_pkg::OFS_DATA;
   localparam logic [7:0] A_LSR = uart_lsr_pkg::OFS_LSR;
   localparam logic [7:0] A_CTL = uart_lsr_pkg::OFS_CTRL;
   localparam logic [7:0] A_IST = uart_lsr_pkg::OFS_IRQ_STAT;
   localparam logic [7:0] A_ICL = uart_lsr_pkg::OFS_IRQ_CLR;
   localparam logic [7:0] A_IEN = uart_lsr_pkg::OFS_IRQ_EN;
   logic        sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        rx_pin, rx_bit_tick, rx_char_valid, rx_parity_err, rx_frame_err;
   logic [7:0]  rx_char_data, tx_wr_data, line_status;
   logic        tx_shift_load, tx_shift_busy, tx_wr_valid, go;
   int          n_taken;
   int          failures, n_compared;
   assign hready = hreadyout; // single slave drives bus ready

   uart_line_status_flags dut_u (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .serial_receive_input(rx_pin), .rx_bit_tick(rx_bit_tick),
      .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_parity_err(rx_parity_err),
      .rx_frame_err(rx_frame_err), .tx_shift_load(tx_shift_load), .tx_shift_busy(tx_shift_busy),
      .tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data), .line_status(line_status), .irq(irq));
   tx_model tx_u (.sys_clk(sys_clk), .nrst(nrst), .go(go), .tx_wr_valid(tx_wr_valid),
      .tx_shift_load(tx_shift_load), .tx_shift_busy(tx_shift_busy), .n_taken(n_taken));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // shared tasks
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for ready seen high at a rising edge, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         $display("[ERR] %0t bus hang", $time);
         report_and_stop();
      end
      @(posedge sys_clk);
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(a, 1'b0, 32'h00000000, r);
      chk(r, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one received char from the receiver side
   task automatic rx_char(input logic [7:0] d, input logic pe, input logic fe);
      rx_char_valid <= 1'b1;
      rx_char_data  <= d;
      rx_parity_err <= pe;
      rx_frame_err  <= fe;
      @(posedge sys_clk);
      rx_char_valid <= 1'b0;
      idle(3);
   endtask
   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; rx_pin = 1'b1; rx_bit_tick = 1'b0; rx_char_valid = 1'b0; rx_char_data = 8'h00;
      rx_parity_err = 1'b0; rx_frame_err = 1'b0; go = 1'b0; failures = 0; n_compared = 0;
      idle(6);
      nrst <= 1'b1;
      @(posedge sys_clk);
      chk(line_status, 8'h60);
      rd(A_LSR, 32'h60);
      rd(A_CTL, 32'ha0);
      rd(8'h20, 32'h0);
      chk(hresp, 1'b0);
      wr(A_LSR, 32'hff);
      rd(A_LSR, 32'h60);
      tdone("reset");
      // non-fifo transmit with a stalled shifter
      wr(A_IEN, 32'h4);
      idle(3);
      chk(irq, 1'b1);
      wr(A_DAT, 32'h3c);
      chk(tx_wr_data, 32'h3c);
      rd(A_LSR, 32'h00);
      wr(A_ICL, 32'h4);
      idle(3);
      chk(irq, 1'b0);
      go <= 1'b1;
      idle(2); // the load reaches the flags two edges after go
      rd(A_LSR, 32'h20);
      idle(80);
      rd(A_LSR, 32'h60);
      chk(irq, 1'b1);
      tdone("tx_single");
      // non-fifo receive: parity then overrun
      rx_char(8'h5a, 1'b1, 1'b0);
      rd(A_LSR, 32'h65);
      rx_char(8'h77, 1'b0, 1'b0);
      rd(A_LSR, 32'h67);
      rd(A_DAT, 32'h5a);
      rd(A_LSR, 32'h60);
      rd(A_IST, 32'h7);
      wr(A_ICL, 32'h3);
      rd(A_IST, 32'h4);
      wr(A_IEN, 32'h0);
      idle(3);
      chk(irq, 1'b0);
      tdone("rx_single");
      // fifo mode, 10 bit frames: error summary follows the contents
      wr(A_CTL, 32'ha1);
      rx_char(8'h11, 1'b0, 1'b0);
      rx_char(8'h22, 1'b0, 1'b1);
      rx_char(8'h33, 1'b0, 1'b0);
      rd(A_LSR, 32'he1);
      rd(A_DAT, 32'h11);
      rd(A_LSR, 32'he9);
      rd(A_DAT, 32'h22);
      rd(A_LSR, 32'h61);
      rd(A_DAT, 32'h33);
      rd(A_LSR, 32'h60);
      tdone("rx_fifo");
      // long break: only one break char expected
      rx_pin <= 1'b0;
      idle(4);
      repeat (20) begin
         rx_bit_tick <= 1'b1;
         @(posedge sys_clk);
         rx_bit_tick <= 1'b0;
         idle(2);
      end
      rx_pin <= 1'b1;
      idle(4);
      rd(A_LSR, 32'hf9);
      rd(A_DAT, 32'h00);
      rd(A_LSR, 32'h60);
      tdone("break");
      // fifo transmit, two chars queued behind a stall
      go <= 1'b0;
      wr(A_DAT, 32'h01);
      wr(A_DAT, 32'h02);
      rd(A_LSR, 32'h00);
      go <= 1'b1;
      idle(200);
      rd(A_LSR, 32'h60);
      chk(n_taken, 3);
      chk(line_status, 8'h60);
      tdone("tx_fifo");
      report_and_stop();
   end
endmodule // tb_top
